// >>> dil_latch.sv
`timescale 1ns/10ps
// ============================================================
// input latch, code driver and sleep control of the converter
//
// Function
// - accept ten-bit unsigned word plus clock
// - all ones gives full scale, complement remainder
// - latch input, update only on rising edge
// - run correctly up to 165 MSPS
// - sleep high powers down, current off
// - sleep pulled low keeps converter enabled
// - power down within 50 ns, up 5 us
// - code range 0 to 1023 inclusive
module dil_latch
  import dil_pkg::*;
#(
  parameter int PU_CYCLES = DIL_PU_CYC,              // power-up wait
  parameter int BUF_DEPTH = DIL_BUF_DEPTH            // staging entries
) (
  input  wire logic            ref_clk_i,
  input  wire logic            nrst_i,
  input  wire logic            smp_valid_i,          // sample offered
  output logic                 smp_ready_o,          // sample accepted
  input  wire dil_code_t       smp_data_i,           // sample code
  input  wire logic            sleep_i,              // power-down request
  input  wire logic            conv_ready_i,         // converter can take
  output dil_word_t            dac_word_o,           // shares to outputs
  output logic                 current_on_o,         // output current on
  output logic                 code_valid_o,         // code may be used
  output logic                 asleep_o              // powered down
);

  // counter wide enough to hold the full wait
  localparam int CNT_W  = $clog2(PU_CYCLES + 1);
  // power-down bound in cycles, used by the checks only
  localparam int PD_MAX = DIL_PD_CYC;                // assertion bound

  // ============================================================
  // elaboration checks
  if (DIL_CLK_MHZ > DIL_MAX_RATE_MSPS) begin : g_rate
    $error("dil_latch: clock above top update rate");
  end
  if (PU_CYCLES < 1) begin : g_pu
    $error("dil_latch: power-up wait must be at least one cycle");
  end

  typedef struct packed {
    dil_state_t       st;                            // power state
    logic [CNT_W-1:0] cnt;                           // power-up counter
    dil_word_t        word;                          // held code pair
    logic             loaded;                        // a code was taken
    logic             on;                            // current enabled
  } dil_ctl_st_t;

  dil_ctl_st_t q;                                    // registered state
  dil_ctl_st_t d;                                    // next state
  logic        buf_valid;                            // staged word ready
  logic        buf_take;                             // latch takes word
  dil_code_t   buf_data;                             // staged word

  // ============================================================
  // staging buffer: a stalled converter back-pressures the source
  dil_buf #(
    .W     (DIL_DATA_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .ref_clk_i   (ref_clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (smp_valid_i),
    .in_ready_o  (smp_ready_o),
    .in_data_i   (smp_data_i),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_take),
    .out_data_o  (buf_data)
  );

  // only a running converter with room takes a word
  assign buf_take = buf_valid && conv_ready_i && (q.st == st_run);

  // word and current straight from flops; asleep_o and code_valid_o decoded from them
  assign dac_word_o   = q.word;
  assign current_on_o = q.on;
  assign asleep_o     = (q.st == st_sleep);
  assign code_valid_o = (q.st == st_run) && q.loaded;

  // ============================================================
  // next state
  always_comb begin
    d = q;
    // master side: new word moves to the slave on the edge
    if (buf_take) begin
      d.word.primary    = buf_data;
      d.word.complement = dil_compl(buf_data);
      d.loaded          = 1'b1;
    end
    case (q.st)
      st_run: begin
        // only a high level sleeps; low keeps running
        if (sleep_i) begin
          d.st = st_sleep;
          d.on = 1'b0;
        end
      end
      st_sleep: begin
        // current stays off until the request drops
        d.on = 1'b0;
        if (!sleep_i) begin
          d.st  = st_wake;
          d.cnt = '0;
          d.on  = 1'b1;
        end
      end
      st_wake: begin
        // code treated invalid until the wait has run out
        if (sleep_i) begin
          d.st = st_sleep;
          d.on = 1'b0;
        end else if (q.cnt == CNT_W'(PU_CYCLES - 1)) begin
          d.st = st_run;
        end else begin
          d.cnt = CNT_W'(q.cnt + 1'b1);
        end
      end
      default: begin
        d.st = st_sleep;
        d.on = 1'b0;
      end
    endcase
  end

  // ============================================================
  // state register
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      // reset comes up running, with no power-up wait
      q.st                <= st_run;
      q.cnt               <= '0;
      q.word.primary      <= DIL_CODE_RST;
      q.word.complement   <= DIL_CODE_MAX;
      q.loaded            <= 1'b0;
      q.on                <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ============================================================
  // checks
  a_code_update: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) buf_take |=>
    dac_word_o.primary == $past(buf_data))
    else $error("taken word not on the output");
  a_code_hold: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) !buf_take |=> $stable(dac_word_o))
    else $error("output code changed without a take");
  a_share_sum: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i)
    ({1'b0, dac_word_o.primary} + {1'b0, dac_word_o.complement})
    == {1'b0, DIL_CODE_MAX})
    else $error("shares do not add to full scale");
  a_full_scale: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) dac_word_o.primary == DIL_CODE_MAX |->
    dac_word_o.complement == '0)
    else $error("full-scale code leaves complement current");
  a_pd_entry: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) (sleep_i && q.st != st_sleep) |=>
    (!current_on_o && asleep_o))
    else $error("sleep request did not power down");
  a_pd_time: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) $rose(sleep_i) |-> ##[1:PD_MAX] !current_on_o)
    else $error("power-down slower than allowed");
  a_wake_hold: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) (q.st == st_wake) |-> !code_valid_o)
    else $error("code valid during power-up wait");
  a_wake_end: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i)
    (q.st == st_wake && !sleep_i && q.cnt == CNT_W'(PU_CYCLES - 1))
    |=> (q.st == st_run && current_on_o))
    else $error("power-up did not finish on time");
  a_sleep_off: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) asleep_o |-> (!current_on_o && !code_valid_o))
    else $error("current on while asleep");
  a_low_runs: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) (q.st == st_run && !sleep_i) |=> !asleep_o)
    else $error("powered down without a request");

  // ============================================================
  // power-state and share checks

  // no take may move the held code outside the run state
  a_sleep_hold: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) (q.st != st_run) |=> $stable(dac_word_o))
    else $error("held code moved outside the run state");

  // a converter outside the run state leaves staged words in the buffer
  a_stall_keeps: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) (q.st != st_run && buf_valid) |=> buf_valid)
    else $error("staged word lost while not running");

  // dropping the request starts the wait from zero
  a_wake_start: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) (asleep_o && !sleep_i) |=>
    (q.st == st_wake && q.cnt == '0 && current_on_o && !asleep_o))
    else $error("power-up wait did not start");

  // the wait counter never passes its last value
  a_wait_range: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) (q.st == st_wake) |->
    (q.cnt < CNT_W'(PU_CYCLES)))
    else $error("power-up counter ran past its end");

  // a code only turns valid with a held code and current on
  a_valid_loaded: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) $rose(code_valid_o) |->
    (q.loaded && !asleep_o && current_on_o))
    else $error("code marked valid without a held code");

  // both shares move together, never one alone
  a_pair_change: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) $changed(dac_word_o.primary) |->
    $changed(dac_word_o.complement))
    else $error("shares changed apart");

  c_full_scale: cover property (@(posedge ref_clk_i)
    disable iff (!nrst_i) buf_take && buf_data == DIL_CODE_MAX);
  c_wake_done: cover property (@(posedge ref_clk_i)
    disable iff (!nrst_i) q.st == st_wake ##1 q.st == st_run);
  c_stall: cover property (@(posedge ref_clk_i)
    disable iff (!nrst_i) smp_valid_i && !smp_ready_o);
  c_back2back: cover property (@(posedge ref_clk_i)
    disable iff (!nrst_i) buf_take [*3]);

endmodule // dil_latch

// >>> dil_pkg.sv
// ============================================================
// shared constants and types for the converter input latch
package dil_pkg;

  // ============================================================
  // data word layout
  localparam int          DIL_DATA_W   = 10;         // sample word width
  localparam logic [9:0]  DIL_CODE_MAX = 10'h3ff;    // full-scale code
  localparam logic [9:0]  DIL_CODE_RST = 10'h000;    // code after reset
  localparam int          DIL_BUF_DEPTH = 2;         // staging entries

  // ============================================================
  // timing
  localparam int DIL_CLK_MHZ       = 100;            // ref clock rate
  localparam int DIL_MAX_RATE_MSPS = 165;            // top update rate
  localparam int DIL_PD_TIME_NS    = 50;             // power-down, longest
  localparam int DIL_PU_TIME_US    = 5;              // power-up wait
  // longest time rounds down, never below one cycle
  localparam int DIL_PD_CYC = (DIL_PD_TIME_NS * DIL_CLK_MHZ / 1000 < 1) ?
                              1 : DIL_PD_TIME_NS * DIL_CLK_MHZ / 1000;
  // least wait rounds up
  localparam int DIL_PU_CYC = DIL_PU_TIME_US * DIL_CLK_MHZ;

  // ============================================================
  // types
  typedef logic [DIL_DATA_W-1:0] dil_code_t;         // unsigned code

  typedef struct packed {
    dil_code_t primary;                              // primary share
    dil_code_t complement;                           // remainder share
  } dil_word_t;

  typedef enum logic [1:0] {
    st_run,
    st_sleep,
    st_wake
  } dil_state_t;

  // complementary share of full scale
  function automatic dil_code_t dil_compl(input dil_code_t code);
    return DIL_CODE_MAX - code;
  endfunction

endpackage

// >>> dil_buf.sv
`timescale 1ns/10ps
// ============================================================
// small staging fifo with valid/ready on both sides
module dil_buf
  import dil_pkg::*;
#(
  parameter int W     = DIL_DATA_W,                  // entry width
  parameter int DEPTH = DIL_BUF_DEPTH                // entry count
) (
  input  wire logic         ref_clk_i,
  input  wire logic         nrst_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // ============================================================
  // elaboration checks
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || W < 1) begin : g_chk
    $error("dil_buf: depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;                    // entry storage
    logic [PW-1:0]           wp;                     // write pointer
    logic [PW-1:0]           rp;                     // read pointer
    logic [CW-1:0]           cnt;                    // fill level
  } dil_buf_st_t;

  dil_buf_st_t q;                                    // registered state
  dil_buf_st_t d;                                    // next state
  logic        push;                                 // word accepted
  logic        pop;                                  // word delivered

  // honest full and empty
  assign in_ready_o  = (q.cnt != CW'(DEPTH));
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o  = q.mem[q.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // ============================================================
  // next state
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data_i;
      d.wp        = PW'(q.wp + 1'b1);
    end
    if (pop) begin
      d.rp = PW'(q.rp + 1'b1);
    end
    case ({push, pop})
      2'b10:   d.cnt = CW'(q.cnt + 1'b1);            // fill
      2'b01:   d.cnt = CW'(q.cnt - 1'b1);            // drain
      default: d.cnt = q.cnt;                        // both or none
    endcase
  end

  // ============================================================
  // state register
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ============================================================
  // checks
  a_buf_no_overflow: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) q.cnt <= CW'(DEPTH))
    else $error("buffer fill level above depth");
  a_buf_order: assert property (@(posedge ref_clk_i)
    disable iff (!nrst_i) (q.cnt == '0 && push) |=>
    (out_valid_o && out_data_o == $past(in_data_i)))
    else $error("buffer lost first word");
  c_buf_full: cover property (@(posedge ref_clk_i)
    disable iff (!nrst_i) !in_ready_o ##1 pop);

endmodule // dil_buf

// >>> dil_src.sv
`timescale 1ns/10ps
// ============================================================
// sample source model: offers queued words over valid/ready
module dil_src
  import dil_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic nrst_i,
  input  wire logic smp_ready_i,
  output logic      smp_valid_o,
  output dil_code_t smp_data_o
);
  dil_code_t q_words[$];                 // words still to offer

  // word and valid held until taken; idle data toggles every cycle
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      smp_valid_o <= 1'b0;
      smp_data_o  <= 10'h155;
    end else if (!smp_valid_o || smp_ready_i) begin
      if (q_words.size() > 0) begin
        smp_valid_o <= 1'b1;
        smp_data_o  <= q_words.pop_front();
      end else begin
        smp_valid_o <= 1'b0;
        smp_data_o  <= ~smp_data_o;
      end
    end
  end

  // queue one word for sending
  task automatic push(input dil_code_t w);
    q_words.push_back(w);
  endtask
endmodule // dil_src

// >>> tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
  num_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, a, b); \
  end end
// ============================================================
// bench: stream, stall, sleep and wake of the input latch
module tb;
  import dil_pkg::*;
  localparam int PU = 4;                  // short power-up wait
  logic      ref_clk_i = 1'b0;            // 50% duty clock
  logic      nrst_i = 1'b0;
  logic      sleep_i = 1'b0;              // starts low, enabled until the sleep phase
  logic      conv_ready_i = 1'b0;
  logic      smp_valid, smp_ready, current_on, code_valid, asleep;
  dil_code_t smp_data, prev;
  dil_word_t dac_word, last_word = {10'h000, 10'h3ff};
  dil_code_t exp_q[$];                    // expected codes in order
  int        num_errors = 0, total_checks = 0, seed = 32'h3773, i, n;

  dil_latch #(.PU_CYCLES(PU), .BUF_DEPTH(2)) uut (.ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i), .smp_valid_i(smp_valid), .smp_ready_o(smp_ready),
    .smp_data_i(smp_data), .sleep_i(sleep_i), .conv_ready_i(conv_ready_i),
    .dac_word_o(dac_word), .current_on_o(current_on),
    .code_valid_o(code_valid), .asleep_o(asleep));
  dil_src src (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
    .smp_ready_i(smp_ready), .smp_valid_o(smp_valid),
    .smp_data_o(smp_data));

  // ============================================================
  // clock
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  // ============================================================
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // queue a word at the source and note it as expected
  task automatic send(input dil_code_t v);
    src.push(v);
    exp_q.push_back(v);
    prev = v;
  endtask

  // random word that differs from the one before
  task automatic send_rand();
    dil_code_t v;
    v = dil_code_t'($random(seed));
    if (v == prev) v = ~v;
    send(v);
  endtask

  // wait for every noted word to reach the outputs
  task automatic drain();
    for (n = 0; n < 200 && exp_q.size() > 0; n++) @(posedge ref_clk_i);
    if (n == 200) begin
      num_errors++;
      summarize();
    end
  endtask

  // ============================================================
  // monitor: each new code is the oldest note, with its remainder
  always @(negedge ref_clk_i) begin
    if (nrst_i && dac_word !== last_word) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        `CHK(dac_word.primary, exp_q[0])
        `CHK(dac_word.complement, DIL_CODE_MAX - exp_q[0])
        void'(exp_q.pop_front());
      end
      last_word = dac_word;
    end
  end

  // code changes only just after a rising edge
  always @(dac_word) begin
    if (nrst_i) `CHK(ref_clk_i, 1'b1)
  end

  // ============================================================
  // main sequence
  initial begin
    repeat (4) @(posedge ref_clk_i);
    `CHK(smp_ready, 1'b1)
    `CHK(dac_word, {10'h000, 10'h3ff})
    `CHK({current_on, code_valid, asleep}, 3'b100)
    nrst_i <= 1'b1;
    // fill the buffer while the converter stalls
    send(10'h3ff);
    send(10'h000);
    send_rand();
    repeat (6) @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    `CHK({smp_ready, smp_valid, code_valid}, 3'b010)
    // stream with random converter stalls
    for (i = 0; i < 40; i++) begin
      @(posedge ref_clk_i);
      send_rand();
      conv_ready_i <= 1'($random(seed));
    end
    @(posedge ref_clk_i);
    conv_ready_i <= 1'b1;
    drain();
    `CHK(code_valid, 1'b1)
    // sleep: current off at once, code held, no take
    @(posedge ref_clk_i);
    sleep_i <= 1'b1;
    send_rand();
    send_rand();
    // request is taken at the next rising edge, asleep from that same edge
    repeat (2) @(negedge ref_clk_i);
    `CHK({current_on, asleep, code_valid}, 3'b010)
    repeat (6) @(negedge ref_clk_i);
    `CHK(dac_word, last_word)
    `CHK(exp_q.size(), 2)
    // short wake cut by a new request restarts the wait
    @(posedge ref_clk_i);
    sleep_i <= 1'b0;
    repeat (2) @(negedge ref_clk_i);
    `CHK({current_on, asleep, code_valid}, 3'b100)
    @(posedge ref_clk_i);
    sleep_i <= 1'b1;
    @(negedge ref_clk_i);
    @(negedge ref_clk_i);
    `CHK(asleep, 1'b1)
    @(posedge ref_clk_i);
    sleep_i <= 1'b0;
    for (n = 0; n < 20; n++) begin
      @(negedge ref_clk_i);
      if (code_valid === 1'b1) break;
    end
    `CHK(n, PU + 1)
    drain();
    `CHK(exp_q.size(), 0)
    summarize();
  end
endmodule // tb
